// File: rtl/sdct_pkg.sv
// ==========================================================================
// Pin widths and field positions
package sdct_pkg;

	localparam int ADDR_W      = 12;
	localparam int BANK_BIT    = 11;
	localparam int AUTO_BIT    = 10;
	localparam int ROW_W       = 11;
	localparam int COL_W       = 8;
	localparam int MASK_W      = 2;
	localparam int DATA_W      = 16;
	localparam int NUM_BANKS   = 2;
	localparam int BURST_SEL_W = 3;

	// ==========================================================================
	// Mode setting
	localparam int                     MODE_BL_LSB   = 0;
	localparam logic [BURST_SEL_W-1:0] MODE_BL8_CODE = 3'h3;
	localparam logic [BURST_SEL_W-1:0] BURST_LAST4   = 3'h3;
	localparam logic [BURST_SEL_W-1:0] BURST_LAST8   = 3'h7;
	localparam logic [BURST_SEL_W-1:0] BURST_FIRST   = 3'h0;
	localparam logic [BURST_SEL_W-1:0] BURST_SECOND  = 3'h1;

	// ==========================================================================
	// Cycle figures
	localparam int CLK_PERIOD_NS          = 25;
	localparam int CAS_LATENCY            = 2;
	localparam int CS_TO_CMD_CYCLES       = 0;
	localparam int CKE_TO_CLK_CYCLES      = 1;
	localparam int MASK_TO_INPUT_CYCLES   = 0;
	localparam int mask_to_output_cycles  = 2;
	localparam int CLOSE_TO_HIZ_CYCLES    = 2;
	localparam int stop_to_command_cycles = 2;
	localparam int WRITE_TO_COLUMN_CYCLES = 1;
	localparam int RD_END_CYCLES          = 1;
	localparam int WR_END_CYCLES          = 2;
	localparam logic [1:0] READ_TAIL  = 2'(CAS_LATENCY - 1 + RD_END_CYCLES);
	localparam logic [1:0] WRITE_TAIL = 2'(WR_END_CYCLES);
	localparam logic [1:0] TAIL_LAST  = 2'h1;
	localparam logic [1:0] TAIL_NONE  = 2'h0;

	// ==========================================================================
	// Controller-side delays in ns and in cycles
	localparam int OPEN_TO_CLOSE_MIN_NS    = 72;
	localparam int OPEN_TO_CLOSE_MAX_NS    = 100000;
	localparam int ROW_CYCLE_NS            = 108;
	localparam int OPEN_TO_COLUMN_NS       = 30;
	localparam int CLOSE_TO_OPEN_NS        = 36;
	localparam int BANK_TO_BANK_OPEN_NS    = 24;
	localparam int MODE_TO_COMMAND_NS      = 30;
	localparam int AUTOCLOSE_WRITE_OPEN_NS = 60;
	localparam int WRITE_RECOVERY_NS       = 20;

	function automatic int ns_min_cycles(input int ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction : ns_min_cycles

	localparam int OPEN_TO_CLOSE_DELAY     = ns_min_cycles(OPEN_TO_CLOSE_MIN_NS);
	localparam int OPEN_TO_CLOSE_MAX_CYC   = OPEN_TO_CLOSE_MAX_NS / CLK_PERIOD_NS;
	localparam int ROW_CYCLE_DELAY         = ns_min_cycles(ROW_CYCLE_NS);
	localparam int OPEN_TO_COLUMN_DELAY    = ns_min_cycles(OPEN_TO_COLUMN_NS);
	localparam int CLOSE_TO_OPEN_DELAY     = ns_min_cycles(CLOSE_TO_OPEN_NS);
	localparam int BANK_TO_BANK_OPEN_DELAY = ns_min_cycles(BANK_TO_BANK_OPEN_NS);
	localparam int MODE_TO_COMMAND_DELAY   = ns_min_cycles(MODE_TO_COMMAND_NS);
	localparam int AUTOCLOSE_WRITE_DELAY   = ns_min_cycles(AUTOCLOSE_WRITE_OPEN_NS);
	localparam int WRITE_RECOVERY_DELAY    = ns_min_cycles(WRITE_RECOVERY_NS);

	// ==========================================================================
	// Types
	typedef enum logic [3:0] {
		CMD_NOP,
		CMD_OPEN,
		CMD_CLOSE,
		close_all_banks_cmd,
		CMD_READ,
		CMD_READ_AC,
		column_write_cmd,
		column_write_autoclose_cmd,
		CMD_STOP,
		auto_refresh_cmd,
		mode_set_cmd
	} sdct_cmd_t;

	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_READ,
		ACC_WRITE
	} sdct_acc_t;

	// Mask bit 0 is low_byte_mask, bit 1 is high_byte_mask
	typedef struct packed {
		logic              cke;
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic [ADDR_W-1:0] addr;
		logic [MASK_W-1:0] mask;
	} sdct_pins_t;

endpackage : sdct_pkg

// File: rtl/sdct_burst_col.sv
// ==========================================================================
// Burst column stepping with wrap inside the aligned block
module sdct_burst_col
	import sdct_pkg::*;
#(
	parameter int P_COL_W = COL_W
)
(
	input  wire logic [P_COL_W-1:0]     i_start_col,
	input  wire logic [BURST_SEL_W-1:0] i_index,
	input  wire logic                   i_bl8,
	output logic      [P_COL_W-1:0]     o_col
);
	logic [BURST_SEL_W-1:0] low8;
	logic [BURST_SEL_W-1:0] low4;

	always_comb
	begin
		low8 = i_start_col[BURST_SEL_W-1:0] + i_index;
		low4 = {i_start_col[BURST_SEL_W-1],
			i_start_col[BURST_SEL_W-2:0] + i_index[BURST_SEL_W-2:0]};
		o_col = {i_start_col[P_COL_W-1:BURST_SEL_W], (i_bl8 ? low8 : low4)};
	end

endmodule : sdct_burst_col

// File: rtl/sdct_device.sv
module sdct_device
	import sdct_pkg::*;
#(
	parameter int P_DATA_W = DATA_W,
	parameter int P_ROW_W  = ROW_W,
	parameter int P_COL_W  = COL_W
)
(
	input  wire logic                 i_clock,
	input  wire logic                 i_srst,
	input  wire sdct_pkg::sdct_pins_t i_pins,
	input  wire logic [P_DATA_W-1:0]  i_dq,
	output logic      [P_DATA_W-1:0]  o_dq,
	output logic      [MASK_W-1:0]    o_dq_oe,
	output logic      [NUM_BANKS-1:0] o_bank_open,
	output logic                      o_access_busy,
	output logic                      o_burst_len8
);
	import sdct_pkg::*;

	localparam int LANE_W = P_DATA_W / MASK_W;
	localparam int MEM_AW = 1 + P_ROW_W + P_COL_W;

	// ==========================================================================
	// Clock enable and command decode
	logic      cke_prev_reg;
	logic      en;
	sdct_cmd_t cmd;
	logic      cmd_bank;
	logic      cmd_auto;

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			cke_prev_reg <= 1'h1;
		else
			cke_prev_reg <= i_pins.cke;
	end

	assign en       = cke_prev_reg;
	assign cmd_bank = ~i_pins.addr[BANK_BIT];
	assign cmd_auto = i_pins.addr[AUTO_BIT];

	always_comb
	begin
		cmd = CMD_NOP;
		if (en && !i_pins.cs_n)
		begin
			case ({i_pins.ras_n, i_pins.cas_n, i_pins.we_n})
				3'h0: cmd = mode_set_cmd;
				3'h1: cmd = auto_refresh_cmd;
				3'h2: cmd = cmd_auto ? close_all_banks_cmd : CMD_CLOSE;
				3'h3: cmd = CMD_OPEN;
				3'h4: cmd = cmd_auto ? column_write_autoclose_cmd : column_write_cmd;
				3'h5: cmd = cmd_auto ? CMD_READ_AC : CMD_READ;
				3'h6: cmd = CMD_STOP;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	// ==========================================================================
	// Access control signals
	logic [NUM_BANKS-1:0]   open_reg;
	logic [P_ROW_W-1:0]     row_reg [NUM_BANKS];
	logic                   bl8_reg;
	sdct_acc_t              acc_state_reg;
	logic [BURST_SEL_W-1:0] acc_cnt_reg;
	logic                   acc_bank_reg;
	logic [P_COL_W-1:0]     acc_col_reg;
	logic                   acc_auto_reg;
	logic [1:0]             tail_reg;
	logic                   is_col_rd;
	logic                   is_col_wr;
	logic                   kill_burst;
	logic                   hiz_now;
	logic                   busy;
	logic                   auto_close_now;
	logic [BURST_SEL_W-1:0] burst_last;

	assign is_col_rd = (cmd == CMD_READ || cmd == CMD_READ_AC) && open_reg[cmd_bank];
	assign is_col_wr = (cmd == column_write_cmd || cmd == column_write_autoclose_cmd)
		&& open_reg[cmd_bank];
	assign hiz_now = (cmd == close_all_banks_cmd)
		|| (cmd == CMD_CLOSE && cmd_bank == acc_bank_reg);
	assign kill_burst = (acc_state_reg != ACC_IDLE)
		&& (cmd == CMD_STOP || hiz_now || is_col_rd || is_col_wr);
	assign busy = (acc_state_reg != ACC_IDLE) || (tail_reg != TAIL_NONE);
	assign auto_close_now = en && acc_auto_reg && (((acc_state_reg == ACC_IDLE)
		&& (tail_reg == TAIL_LAST)) || (busy && (is_col_rd || is_col_wr)));
	assign burst_last = bl8_reg ? BURST_LAST8 : BURST_LAST4;

	// ==========================================================================
	// Bank state and mode
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			open_reg   <= '0;
			row_reg[0] <= '0;
			row_reg[1] <= '0;
			bl8_reg    <= 1'h0;
		end
		else if (en)
		begin
			case (cmd)
				CMD_OPEN:
					if (!open_reg[cmd_bank])
					begin
						open_reg[cmd_bank] <= 1'h1;
						row_reg[cmd_bank]  <= i_pins.addr[P_ROW_W-1:0];
					end
				CMD_CLOSE: open_reg[cmd_bank] <= 1'h0;
				close_all_banks_cmd: open_reg <= '0;
				mode_set_cmd:
					if (open_reg == '0)
						bl8_reg <= (i_pins.addr[MODE_BL_LSB +: BURST_SEL_W]
							== MODE_BL8_CODE);
				default: ;
			endcase
			if (auto_close_now)
				open_reg[acc_bank_reg] <= 1'h0;
		end
	end

	// ==========================================================================
	// Burst sequencing
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			acc_state_reg <= ACC_IDLE;
			acc_cnt_reg   <= BURST_FIRST;
			acc_bank_reg  <= 1'h0;
			acc_col_reg   <= '0;
			acc_auto_reg  <= 1'h0;
			tail_reg      <= TAIL_NONE;
		end
		else if (en)
		begin
			if (tail_reg != TAIL_NONE)
				tail_reg <= tail_reg - TAIL_LAST;
			if (is_col_rd || is_col_wr)
			begin
				acc_state_reg <= is_col_rd ? ACC_READ : ACC_WRITE;
				acc_cnt_reg   <= is_col_rd ? BURST_FIRST : BURST_SECOND;
				acc_bank_reg  <= cmd_bank;
				acc_col_reg   <= i_pins.addr[P_COL_W-1:0];
				acc_auto_reg  <= cmd_auto;
				tail_reg      <= TAIL_NONE;
			end
			else if (kill_burst)
			begin
				acc_state_reg <= ACC_IDLE;
				acc_auto_reg  <= 1'h0;
				tail_reg      <= TAIL_NONE;
			end
			else
			begin
				case (acc_state_reg)
					ACC_READ, ACC_WRITE:
					begin
						acc_cnt_reg <= acc_cnt_reg + BURST_SECOND;
						if (acc_cnt_reg == burst_last)
						begin
							acc_state_reg <= ACC_IDLE;
							tail_reg <= (acc_state_reg == ACC_READ) ? READ_TAIL
								: WRITE_TAIL;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ==========================================================================
	// Burst column and memory array
	logic [P_DATA_W-1:0]    mem [2**MEM_AW];
	logic [P_COL_W-1:0]     cur_col;
	logic                   cur_bank;
	logic [MEM_AW-1:0]      cur_addr;
	logic [P_DATA_W-1:0]    merged;
	logic                   wr_now;

	assign cur_bank = is_col_wr ? cmd_bank : acc_bank_reg;
	assign cur_addr = {cur_bank, row_reg[cur_bank], cur_col};
	assign wr_now = en && (is_col_wr || ((acc_state_reg == ACC_WRITE) && !kill_burst));

	sdct_burst_col #(
		.P_COL_W(P_COL_W)
	) u_burst_col (
		.i_start_col(is_col_wr ? i_pins.addr[P_COL_W-1:0] : acc_col_reg),
		.i_index    (is_col_wr ? BURST_FIRST : acc_cnt_reg),
		.i_bl8      (bl8_reg),
		.o_col      (cur_col)
	);

	for (genvar g = 0; g < MASK_W; g++)
	begin : g_lane
		assign merged[g*LANE_W +: LANE_W] = i_pins.mask[g]
			? mem[cur_addr][g*LANE_W +: LANE_W] : i_dq[g*LANE_W +: LANE_W];
	end

	always_ff @(posedge i_clock)
	begin
		if (wr_now)
			mem[cur_addr] <= merged;
	end

	// ==========================================================================
	// Read data path
	logic [MASK_W-1:0] mask_d_reg;

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			mask_d_reg <= '0;
			o_dq       <= '0;
			o_dq_oe    <= '0;
		end
		else if (en)
		begin
			mask_d_reg <= i_pins.mask;
			if ((acc_state_reg == ACC_READ) && !hiz_now)
			begin
				o_dq    <= mem[cur_addr];
				o_dq_oe <= ~mask_d_reg;
			end
			else
				o_dq_oe <= '0;
		end
	end

	// ==========================================================================
	// Status outputs
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			o_bank_open   <= '0;
			o_access_busy <= 1'h0;
			o_burst_len8  <= 1'h0;
		end
		else
		begin
			o_bank_open   <= open_reg;
			o_access_busy <= busy;
			o_burst_len8  <= bl8_reg;
		end
	end

endmodule : sdct_device

// File: tb/sdct_checker.sv
// ==========================================================================
// Port-level timing checks
module sdct_checker
	import sdct_pkg::*;
#(
	parameter int P_DATA_W = DATA_W
)
(
	input wire logic                 i_clock,
	input wire logic                 i_srst,
	input wire sdct_pkg::sdct_pins_t i_pins,
	input wire logic [P_DATA_W-1:0]  i_dq,
	input wire logic [P_DATA_W-1:0]  o_dq,
	input wire logic [MASK_W-1:0]    o_dq_oe,
	input wire logic [NUM_BANKS-1:0] o_bank_open,
	input wire logic                 o_access_busy,
	input wire logic                 o_burst_len8
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       cke_reg;
	logic [2:0] cmd;
	logic       acc, quiet, rd_go, close_go, open_go, mode_go, stop_go;

	always_ff @(posedge i_clock)
		cke_reg <= i_srst | i_pins.cke;
	assign cmd      = {i_pins.ras_n, i_pins.cas_n, i_pins.we_n};
	assign acc      = cke_reg & i_pins.cke & ~i_pins.cs_n;
	assign quiet    = cke_reg & i_pins.cke & i_pins.cs_n & (i_pins.mask == 2'h0);
	assign rd_go    = acc & (cmd == 3'h5) & o_bank_open[~i_pins.addr[BANK_BIT]];
	assign close_go = acc & (cmd == 3'h2) & i_pins.addr[AUTO_BIT];
	assign open_go  = acc & (cmd == 3'h3);
	assign mode_go  = acc & (cmd == 3'h0) & (o_bank_open == 2'h0);
	assign stop_go  = acc & (cmd == 3'h6);

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);

	// ==========================================================================
	// Assertions
	property p_read_mask;
		rd_go |-> ##2 o_dq_oe == ~$past(i_pins.mask, 2);
	endproperty
	a_read_mask: assert property (p_read_mask)
		else $error("read lane enable wrong");
	property p_burst_end;
		rd_go && !o_burst_len8 && i_pins.mask == 2'h0 ##1 quiet [*4]
			|-> ##1 o_dq_oe == 2'h3 ##1 o_dq_oe == 2'h0;
	endproperty
	a_burst_end: assert property (p_burst_end)
		else $error("four word burst length wrong");
	property p_cke_hold;
		!i_pins.cke |-> ##2 $stable(o_dq) && $stable(o_dq_oe);
	endproperty
	a_cke_hold: assert property (p_cke_hold)
		else $error("outputs moved while clock suspended");
	property p_close_hiz;
		close_go |-> ##[1:2] o_dq_oe == 2'h0;
	endproperty
	a_close_hiz: assert property (p_close_hiz)
		else $error("outputs still driven after close");
	property p_close_flags;
		close_go |-> ##2 o_bank_open == 2'h0;
	endproperty
	a_close_flags: assert property (p_close_flags)
		else $error("bank still open after close all");
	property p_open_t;
		open_go && i_pins.addr[BANK_BIT] |-> ##2 o_bank_open[0];
	endproperty
	a_open_t: assert property (p_open_t)
		else $error("bank T not opened");
	property p_mode_len;
		mode_go |-> ##2 o_burst_len8 == ($past(i_pins.addr[2:0], 2) == MODE_BL8_CODE);
	endproperty
	a_mode_len: assert property (p_mode_len)
		else $error("burst length not taken");
	property p_stop_read;
		stop_go ##1 rd_go |-> ##2 o_dq_oe == ~$past(i_pins.mask, 2);
	endproperty
	a_stop_read: assert property (p_stop_read)
		else $error("read after stop late");
	property p_reset_clear;
		$fell(i_srst) |-> o_dq_oe == 2'h0 && o_bank_open == 2'h0 && !o_access_busy && !o_burst_len8;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("outputs not cleared by reset");

	c_read: cover property (rd_go);
	c_close: cover property (close_go);
	c_stop_read: cover property (stop_go ##1 rd_go);
endmodule : sdct_checker

bind sdct_device sdct_checker #(.P_DATA_W(P_DATA_W)) u_sdct_checker (.i_clock(i_clock),
	.i_srst(i_srst), .i_pins(i_pins), .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
	.o_bank_open(o_bank_open), .o_access_busy(o_access_busy), .o_burst_len8(o_burst_len8));

// File: tb/sdct_ctrl_model.sv
// ==========================================================================
// Command issuing controller
module sdct_ctrl_model
	import sdct_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic [15:0] i_dq,
	input  wire logic [1:0]  i_oe,
	input  wire logic        i_bl8,
	output sdct_pins_t       o_pins,
	output logic      [15:0] o_dq
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] rdat [8];
	logic [1:0]  roe  [8];
	int          hold_at = -1;

	initial
	begin
		o_pins = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
		o_dq   = 16'h0;
	end

	// Spacing before the next command in whole cycles
	function automatic int gap_of(input logic [2:0] c, input int nw);
		case (c)
			3'h3, 3'h1: return ROW_CYCLE_DELAY;
			3'h2: return CLOSE_TO_OPEN_DELAY;
			3'h0: return MODE_TO_COMMAND_DELAY;
			3'h4: return nw + AUTOCLOSE_WRITE_DELAY;
			default: return 11;
		endcase
	endfunction : gap_of

	// One command, then deselect and capture read words
	task automatic op(input logic [3:0] c, input logic [11:0] a, input logic [1:0] m,
		input logic [15:0] d, input int gap);
		int nw;
		nw = i_bl8 ? 8 : 4;
		if (gap == 0)
			gap = gap_of(c[2:0], nw);
		@(posedge i_clock);
		#1;
		o_pins = '{1'b1, c[3], c[2], c[1], c[0], a, m};
		o_dq   = d;
		for (int k = 1; k < gap; k++)
		begin
			@(posedge i_clock);
			if (k >= 3 && k < 11)
			begin
				rdat[k-3] = i_dq;
				roe[k-3]  = i_oe;
			end
			#1;
			o_pins.cs_n = 1'b1;
			o_pins.cke  = (k != hold_at);
			o_dq        = (c[2:0] == 3'h4 && k < nw) ? d + 16'(k) : ~o_dq;
		end
	endtask : op
endmodule : sdct_ctrl_model

// File: tb/sdram_command_timing_tb_top.sv
// ==========================================================================
// Testbench top
module sdram_command_timing_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sdct_pkg::*;
	typedef struct {
		logic       bank;
		logic [7:0] wc, rc;
		logic [1:0] wm, rm;
		logic       b8;
		logic [2:0] ex;
	} sdct_row_t;
	logic        i_clock = 1'b0;
	logic        i_srst  = 1'b1;
	sdct_pins_t  pins;
	logic [15:0] wdq, rdq;
	logic [1:0]  oe, bopen;
	logic        busy, bl8;
	int          n_fail = 0;
	int          total_checks = 0;
	sdct_row_t   rows [4] = '{
		'{1'b1, 8'h0d, 8'h0f, 2'h1, 2'h0, 1'b0, 3'h2},
		'{1'b0, 8'h13, 8'h16, 2'h2, 2'h1, 1'b1, 3'h3},
		'{1'b1, 8'h24, 8'h27, 2'h3, 2'h2, 1'b1, 3'h3},
		'{1'b0, 8'hfa, 8'hf9, 2'h0, 2'h3, 1'b0, 3'h3}};

	sdct_device u_sdct_device (.i_clock(i_clock), .i_srst(i_srst), .i_pins(pins), .i_dq(wdq),
		.o_dq(rdq), .o_dq_oe(oe), .o_bank_open(bopen), .o_access_busy(busy), .o_burst_len8(bl8));
	sdct_ctrl_model u_sdct_ctrl_model (.i_clock(i_clock), .i_dq(rdq), .i_oe(oe), .i_bl8(bl8),
		.o_pins(pins), .o_dq(wdq));

	initial forever #12.5 i_clock = ~i_clock;

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic summarize();
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	function automatic logic [11:0] col_addr(input logic b, input logic [7:0] c);
		return {b, 3'h0, c};
	endfunction : col_addr

	initial
	begin
		#50us;
		n_fail++;
		summarize();
	end

	// ==========================================================================
	// Sequence
	initial
	begin
		int          nw;
		logic [15:0] d1, d2, ln, ex;
		logic [15:0] hold_exp [5];
		hold_exp = '{16'h5e32, 16'h5e32, 16'h5e33, 16'h5e30, 16'h5e31};
		repeat (6) @(posedge i_clock);
		#1;
		i_srst = 1'b0;
		check({14'h0, oe}, 16'h0);
		check({14'h0, bopen}, 16'h0);
		foreach (rows[i])
		begin
			nw = rows[i].b8 ? 8 : 4;
			d1 = 16'ha100 + 16'(i * 16);
			d2 = 16'h5e00 + 16'(i * 16);
			ln = {{8{~rows[i].rm[1]}}, {8{~rows[i].rm[0]}}};
			u_sdct_ctrl_model.op(4'h2, 12'h400, 2'h0, 16'h0, 0);
			u_sdct_ctrl_model.op(4'h0, {9'h0, rows[i].b8 ? MODE_BL8_CODE : 3'h2}, 2'h0, 16'h0, 0);
			u_sdct_ctrl_model.op(4'h3, {rows[i].bank, 11'h0a5}, 2'h0, 16'h0, 0);
			check({15'h0, bl8}, {15'h0, rows[i].b8});
			u_sdct_ctrl_model.op(4'h4, col_addr(rows[i].bank, rows[i].wc), 2'h0, d1, 0);
			u_sdct_ctrl_model.op(4'h4, col_addr(rows[i].bank, rows[i].wc), rows[i].wm, d2, 0);
			check({15'h0, busy}, 16'h1);
			u_sdct_ctrl_model.op(4'h5, col_addr(rows[i].bank, rows[i].rc), rows[i].rm, 16'h0, 0);
			for (int k = 0; k < nw; k++)
			begin
				ex = {rows[i].wm[1] ? d1[15:8] : d2[15:8], rows[i].wm[0] ? d1[7:0] : d2[7:0]};
				ex = ex + 16'((rows[i].ex + k) % nw);
				check(u_sdct_ctrl_model.rdat[k] & ln, ex & ln);
				check({14'h0, u_sdct_ctrl_model.roe[k]}, {14'h0, ~rows[i].rm});
			end
			if (!rows[i].b8)
				check({14'h0, u_sdct_ctrl_model.roe[4]}, 16'h0);
		end
		u_sdct_ctrl_model.hold_at = 1;
		u_sdct_ctrl_model.op(4'h5, col_addr(1'b0, 8'hf8), 2'h0, 16'h0, 0);
		u_sdct_ctrl_model.hold_at = -1;
		for (int k = 0; k < 5; k++)
			check(u_sdct_ctrl_model.rdat[k], hold_exp[k]);
		u_sdct_ctrl_model.op(4'h5, col_addr(1'b0, 8'hf8), 2'h0, 16'h0, 2);
		u_sdct_ctrl_model.op(4'h6, 12'h0, 2'h0, 16'h0, 1);
		u_sdct_ctrl_model.op(4'h5, col_addr(1'b0, 8'hfa), 2'h0, 16'h0, 0);
		for (int k = 0; k < 4; k++)
			check(u_sdct_ctrl_model.rdat[k], 16'h5e30 + 16'(k));
		u_sdct_ctrl_model.op(4'hd, col_addr(1'b0, 8'hf8), 2'h0, 16'h0, 0);
		for (int k = 0; k < 4; k++)
			check({14'h0, u_sdct_ctrl_model.roe[k]}, 16'h0);
		u_sdct_ctrl_model.op(4'h5, col_addr(1'b0, 8'hf8), 2'h0, 16'h0, 2);
		u_sdct_ctrl_model.op(4'h2, 12'h400, 2'h0, 16'h0, 4);
		check({14'h0, u_sdct_ctrl_model.roe[0]}, 16'h0);
		check({14'h0, bopen}, 16'h0);
		u_sdct_ctrl_model.op(4'h3, 12'h8a5, 2'h0, 16'h0, 0);
		u_sdct_ctrl_model.op(4'h5, col_addr(1'b1, 8'h0d) | 12'h400, 2'h0, 16'h0, 0);
		check({14'h0, u_sdct_ctrl_model.roe[0]}, 16'h3);
		check({14'h0, bopen}, 16'h0);
		check({15'h0, busy}, 16'h0);
		summarize();
	end
endmodule : sdram_command_timing_tb_top
